// ### exp_timer_pkg.sv
/*
  Shared constants, register map, field layouts and carrier types for the
  exposure timer with acquisition start trigger delay.
  Assumes a 10 MHz system clock and an APB master with 32-bit data.
*/
package exp_timer_pkg;

  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned CYC_PER_TICK = (CLK_HZ / HZ_PER_MHZ) * TICK_US;

  // widths
  localparam int ADDR_W = 8;
  localparam int DUR_W = 24;
  localparam int MULT_W = 12;
  localparam int PROD_W = DUR_W + MULT_W;
  localparam int CTRL_W = 7;
  localparam int EV_W = 3;

  // multiplier limits and reset value
  localparam logic [MULT_W-1:0] MULT_MIN = 12'h001;
  localparam logic [MULT_W-1:0] MULT_MAX = 12'hfff;
  localparam logic [MULT_W-1:0] MULT_RST = 12'h064;

  // time base, step and maximum exposure per sensor variant
  localparam logic [DUR_W-1:0] BASE_RST_STD = 24'h000014;
  localparam logic [DUR_W-1:0] BASE_RST_RES = 24'h00001f;
  localparam logic [DUR_W-1:0] BASE_STEP_STD = 24'h000001;
  localparam logic [DUR_W-1:0] BASE_STEP_RES = 24'h00001f;
  localparam logic [DUR_W-1:0] MAX_DUR_STD = 24'h989680;
  localparam logic [DUR_W-1:0] MAX_DUR_RES = 24'h01f000;
  localparam logic [DUR_W-1:0] MIN_DUR_DEF = 24'h000010;
  localparam logic [DUR_W-1:0] DELAY_RST = 24'h000000;
  localparam logic [DUR_W-1:0] PERIOD_RST = 24'h000000;

  // register byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] A_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] A_MULT = 8'h0c;
  localparam logic [ADDR_W-1:0] A_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] A_DUR = 8'h14;
  localparam logic [ADDR_W-1:0] A_AUTO = 8'h18;
  localparam logic [ADDR_W-1:0] A_PERIOD = 8'h1c;
  localparam logic [ADDR_W-1:0] A_STATE = 8'h20;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h24;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h28;

  // command bits
  localparam int CMD_ARM = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_SW_TRIG = 2;

  // trigger sources
  localparam logic [1:0] SRC_LINE1 = 2'h0;
  localparam logic [1:0] SRC_LINE2 = 2'h1;
  localparam logic [1:0] SRC_SOFT = 2'h2;

  // event bits
  localparam int EV_OVER = 0;
  localparam int EV_START = 1;
  localparam int EV_END = 2;

  typedef struct packed {
    logic auto_on;
    logic frame_pacing_limit_on;
    logic pulse_length_exposure;
    logic start_edge_polarity;
    logic [1:0] start_trigger_input_select;
    logic start_trigger_on;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = 7'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {ST_WAIT, ST_DELAY, ST_EXPOSE} acq_state_t;

endpackage : exp_timer_pkg

// ### us_tick_gen.sv
/*
  Microsecond tick divider: one-cycle enable pulse every DIV clocks.
  Assumes one clock; restart realigns the phase so a count starts whole.
*/
`timescale 1ns/1ps
module us_tick_gen #(
  parameter int unsigned DIV = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control
  input wire logic restart,
  // tick
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge sys_clk) begin
    if (srst || restart) begin
      cnt_r <= ZERO;
    end else if (cnt_r == LAST) begin
      cnt_r <= ZERO;
    end else begin
      cnt_r <= cnt_r + ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || restart) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == LAST);
    end
  end

endmodule : us_tick_gen

// ### exposure_timer_trigger_delay.sv
/*
  Exposure timing and acquisition start trigger delay with APB registers.
  Assumes a 10 MHz sys_clk, synchronous active-high srst, asynchronous
  trigger pins and an APB master that holds each request until pready.
*/
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - hardware start edge waits the programmed microsecond delay before acting
// - no delay when triggering is off or the trigger is a software command
// - timed exposure never shorter than the variant's minimum exposure time
// - raw exposure equals multiplier times time base
// - multiplier writes outside 1 to 4095 are refused
// - time base resets to 20 us, or 31 us on the restricted variant
// - time base steps of 1 us, or 31 us on the restricted variant
// - time base may reach 10000000 us on standard variants
// - restricted variant caps exposure at 126976 us
// - auto exposure value is used as is, not a multiple of the base
// - auto exposure is blocked while trigger-width mode is selected
// - with pacing limit off no internal frame period gates triggers
// - once armed, rising activation starts acquisition when the line goes high
// - timed mode exposes from the chosen edge for the configured duration
// - width mode exposes from active edge until the opposite edge
// - trigger during delay or exposure is ignored and flags overtrigger
// - absolute request becomes nearest achievable multiplier times base
module exposure_timer_trigger_delay
  import exp_timer_pkg::*;
#(
  parameter bit RESTRICTED = 1'b0,
  parameter logic [23:0] MIN_EXP_US = 24'h000010
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register bus
  input wire exp_timer_pkg::apb_req_t apb_req,
  output exp_timer_pkg::apb_rsp_t apb_rsp,
  // trigger input lines (asynchronous)
  input wire logic [1:0] trig_line,
  // acquisition status
  output logic exposure_active,
  output logic trigger_ready,
  output logic frame_start,
  // interrupt
  output logic irq
);
  import exp_timer_pkg::*;

  localparam logic [DUR_W-1:0] BASE_RST = RESTRICTED ? BASE_RST_RES : BASE_RST_STD;
  localparam logic [DUR_W-1:0] BASE_STEP = RESTRICTED ? BASE_STEP_RES : BASE_STEP_STD;
  localparam logic [DUR_W-1:0] MAX_DUR = RESTRICTED ? MAX_DUR_RES : MAX_DUR_STD;
  localparam logic [DUR_W-1:0] DUR_ONE = 24'h000001;
  localparam logic [DUR_W-1:0] DUR_ZERO = 24'h000000;

  // clamp a product into [min, max]
  function automatic logic [DUR_W-1:0] clamp_dur(input logic [PROD_W-1:0] v);
    logic [DUR_W-1:0] r;
    r = v[DUR_W-1:0];
    if (v > PROD_W'(MAX_DUR)) begin
      r = MAX_DUR;
    end else if (v < PROD_W'(MIN_EXP_US)) begin
      r = MIN_EXP_US;
    end
    return r;
  endfunction : clamp_dur

  // nearest multiplier for an absolute request
  function automatic logic [MULT_W-1:0] near_mult(input logic [DUR_W-1:0] v,
                                                  input logic [DUR_W-1:0] b);
    logic [DUR_W:0] q;
    logic [MULT_W-1:0] r;
    q = ({1'b0, v} + {2'b00, b[DUR_W-1:1]}) / {1'b0, b};
    r = q[MULT_W-1:0];
    if (q > (DUR_W+1)'(MULT_MAX)) begin
      r = MULT_MAX;
    end else if (q < (DUR_W+1)'(MULT_MIN)) begin
      r = MULT_MIN;
    end
    return r;
  endfunction : near_mult

  // registers
  ctrl_t ctrl_r;
  logic [DUR_W-1:0] start_delay_us_r;
  logic [MULT_W-1:0] exposure_multiplier_r;
  logic [DUR_W-1:0] exposure_tick_base_us_r;
  logic [DUR_W-1:0] auto_dur_r;
  logic [DUR_W-1:0] period_us_r;
  logic [DUR_W-1:0] exposure_duration_us_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic armed_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // acquisition state
  acq_state_t state_r;
  logic [DUR_W-1:0] dly_cnt_r;
  logic [DUR_W-1:0] exp_cnt_r;
  logic [DUR_W-1:0] pace_cnt_r;
  logic width_run_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic act_prev_r;
  logic exposure_active_r;
  logic trigger_ready_r;
  logic frame_start_r;

  // bus decode
  logic wr_en;
  logic setup;
  logic [31:0] wd;
  logic [ADDR_W-1:0] ad;
  ctrl_t ctrl_wd;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wd = apb_req.pwdata;
  assign ad = apb_req.paddr;
  assign ctrl_wd = ctrl_t'(wd[CTRL_W-1:0]);

  // trigger derivation
  logic tick;
  logic line_lvl;
  logic act_lvl;
  logic act_edge;
  logic hw_trig;
  logic sw_trig;
  logic free_trig;
  logic pace_ok;
  logic idle_ok;
  logic accept;
  logic go_delay;
  logic go_expose;
  logic end_expose;
  logic auto_eff;
  logic [EV_W-1:0] ev;

  assign line_lvl = sync2_r[ctrl_r.start_trigger_input_select[0]];
  // polarity 1 selects falling activation
  assign act_lvl = line_lvl ^ ctrl_r.start_edge_polarity;
  assign act_edge = act_lvl && !act_prev_r;
  assign hw_trig = ctrl_r.start_trigger_on && (ctrl_r.start_trigger_input_select != SRC_SOFT) && act_edge;
  assign sw_trig = wr_en && (ad == A_CMD) && wd[CMD_SW_TRIG] && ctrl_r.start_trigger_on
                   && (ctrl_r.start_trigger_input_select == SRC_SOFT);
  assign pace_ok = !ctrl_r.frame_pacing_limit_on || (pace_cnt_r == DUR_ZERO);
  assign idle_ok = armed_r && (state_r == ST_WAIT) && pace_ok;
  assign free_trig = !ctrl_r.start_trigger_on && idle_ok;
  assign accept = idle_ok && (hw_trig || sw_trig || free_trig);
  assign go_delay = accept && hw_trig && (start_delay_us_r != DUR_ZERO);
  // software and free-run triggers skip the delay
  assign go_expose = (accept && !go_delay)
                     || (state_r == ST_DELAY && tick && dly_cnt_r == DUR_ONE);
  assign end_expose = (state_r == ST_EXPOSE) && (width_run_r ? !act_lvl
                      : (tick && exp_cnt_r == DUR_ONE));
  assign auto_eff = ctrl_r.auto_on && !ctrl_r.pulse_length_exposure;

  assign ev[EV_OVER] = armed_r && (hw_trig || sw_trig) && !idle_ok;
  assign ev[EV_START] = go_expose;
  assign ev[EV_END] = end_expose;

  us_tick_gen #(
    .DIV(CYC_PER_TICK)
  ) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .restart(go_delay || go_expose),
    .tick(tick)
  );

  // pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= trig_line;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      act_prev_r <= 1'b1;
    end else begin
      act_prev_r <= act_lvl;
    end
  end

  // control register; auto bit cannot coexist with width mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && ad == A_CTRL) begin
      ctrl_r <= ctrl_wd;
      ctrl_r.auto_on <= ctrl_wd.auto_on && !ctrl_wd.pulse_length_exposure;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      start_delay_us_r <= DELAY_RST;
      auto_dur_r <= MIN_EXP_US;
      period_us_r <= PERIOD_RST;
    end else if (wr_en) begin
      if (ad == A_DELAY) begin
        start_delay_us_r <= wd[DUR_W-1:0];
      end
      if (ad == A_AUTO) begin
        auto_dur_r <= clamp_dur(PROD_W'(wd[DUR_W-1:0]));
      end
      if (ad == A_PERIOD) begin
        period_us_r <= wd[DUR_W-1:0];
      end
    end
  end

  // multiplier: raw write in range, or nearest value for an absolute request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exposure_multiplier_r <= MULT_RST;
    end else if (wr_en && ad == A_MULT) begin
      if (wd[31:MULT_W] == '0 && wd[MULT_W-1:0] >= MULT_MIN) begin
        exposure_multiplier_r <= wd[MULT_W-1:0];
      end
    end else if (wr_en && ad == A_DUR) begin
      exposure_multiplier_r <= near_mult(wd[DUR_W-1:0], exposure_tick_base_us_r);
    end
  end

  // time base: non-zero, within maximum, on the variant's step
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exposure_tick_base_us_r <= BASE_RST;
    end else if (wr_en && ad == A_BASE) begin
      if (wd[31:DUR_W] == '0 && wd[DUR_W-1:0] != DUR_ZERO && wd[DUR_W-1:0] <= MAX_DUR
          && (wd[DUR_W-1:0] % BASE_STEP) == DUR_ZERO) begin
        exposure_tick_base_us_r <= wd[DUR_W-1:0];
      end
    end
  end

  // effective exposure duration
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exposure_duration_us_r <= MIN_EXP_US;
    end else if (auto_eff) begin
      exposure_duration_us_r <= auto_dur_r;
    end else begin
      exposure_duration_us_r <= clamp_dur(PROD_W'(exposure_multiplier_r) * PROD_W'(exposure_tick_base_us_r));
    end
  end

  // arm and stop commands
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      armed_r <= 1'b0;
    end else if (wr_en && ad == A_CMD) begin
      if (wd[CMD_STOP]) begin
        armed_r <= 1'b0;
      end else if (wd[CMD_ARM]) begin
        armed_r <= 1'b1;
      end
    end
  end

  // acquisition sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_WAIT;
    end else begin
      case (state_r)
        ST_WAIT: begin
          if (go_delay) begin
            state_r <= ST_DELAY;
          end else if (go_expose) begin
            state_r <= ST_EXPOSE;
          end
        end
        ST_DELAY: begin
          if (go_expose) begin
            state_r <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          if (end_expose) begin
            state_r <= ST_WAIT;
          end
        end
        default: begin
          state_r <= ST_WAIT;
        end
      endcase
    end
  end

  // delay counter in microseconds
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dly_cnt_r <= DUR_ZERO;
    end else if (go_delay) begin
      dly_cnt_r <= start_delay_us_r;
    end else if (state_r == ST_DELAY && tick) begin
      dly_cnt_r <= dly_cnt_r - DUR_ONE;
    end
  end

  // exposure counter; width mode only for a line trigger
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exp_cnt_r <= DUR_ZERO;
      width_run_r <= 1'b0;
    end else if (go_expose) begin
      exp_cnt_r <= exposure_duration_us_r;
      width_run_r <= ctrl_r.pulse_length_exposure && ctrl_r.start_trigger_on
                     && ctrl_r.start_trigger_input_select != SRC_SOFT;
    end else if (state_r == ST_EXPOSE && tick && exp_cnt_r != DUR_ZERO) begin
      exp_cnt_r <= exp_cnt_r - DUR_ONE;
    end
  end

  // internal frame period limiter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pace_cnt_r <= DUR_ZERO;
    end else if (go_expose && state_r != ST_EXPOSE) begin
      pace_cnt_r <= period_us_r;
    end else if (tick && pace_cnt_r != DUR_ZERO) begin
      pace_cnt_r <= pace_cnt_r - DUR_ONE;
    end
  end

  // status outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exposure_active_r <= 1'b0;
      trigger_ready_r <= 1'b0;
      frame_start_r <= 1'b0;
    end else begin
      exposure_active_r <= (state_r == ST_EXPOSE && !end_expose) || go_expose;
      trigger_ready_r <= idle_ok && !accept;
      frame_start_r <= go_expose;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_stat_r <= '0;
    end else if (wr_en && ad == A_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wd[EV_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_mask_r <= '0;
    end else if (wr_en && ad == A_IRQ_MASK) begin
      irq_mask_r <= wd[EV_W-1:0];
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      case (ad)
        A_CTRL: prdata_r <= 32'(ctrl_r);
        A_CMD: prdata_r <= 32'(armed_r);
        A_DELAY: prdata_r <= 32'(start_delay_us_r);
        A_MULT: prdata_r <= 32'(exposure_multiplier_r);
        A_BASE: prdata_r <= 32'(exposure_tick_base_us_r);
        A_DUR: prdata_r <= 32'(exposure_duration_us_r);
        A_AUTO: prdata_r <= 32'(auto_dur_r);
        A_PERIOD: prdata_r <= 32'(period_us_r);
        A_STATE: prdata_r <= {28'h0000000, exposure_active_r, armed_r, state_r};
        A_IRQ_STAT: prdata_r <= 32'(irq_stat_r);
        A_IRQ_MASK: prdata_r <= 32'(irq_mask_r);
        default: pslverr_r <= 1'b1;
      endcase
    end
  end

  // zero wait states; error only shown in the access phase
  assign apb_rsp = '{pready: 1'b1, pslverr: pslverr_r && apb_req.psel && apb_req.penable, prdata: prdata_r};
  assign exposure_active = exposure_active_r;
  assign trigger_ready = trigger_ready_r;
  assign frame_start = frame_start_r;
  assign irq = |(irq_stat_r & irq_mask_r);

endmodule : exposure_timer_trigger_delay

// ### exp_timer_properties.sv
/*
  Port checker for the exposure timer, bound to every instance of it.
  Assumes the top module's port names and its MIN_EXP_US parameter.
*/
`timescale 1ns/1ps
module exp_timer_chk
  import exp_timer_pkg::*;
#(
  parameter logic [23:0] MIN_EXP_US = 24'h000010
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register bus
  input wire exp_timer_pkg::apb_req_t apb_req,
  input wire exp_timer_pkg::apb_rsp_t apb_rsp,
  // status
  input wire logic exposure_active,
  input wire logic trigger_ready,
  input wire logic frame_start,
  input wire logic irq
);
  localparam int unsigned MIN_CYC = MIN_EXP_US * CYC_PER_TICK;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [27:0] exp_cnt_r;
  // length of the exposure in progress, in clocks
  always_ff @(posedge sys_clk) begin
    if (srst || !exposure_active) exp_cnt_r <= 28'h0;
    else exp_cnt_r <= exp_cnt_r + 28'h1;
  end
  property p_fs_rise;
    $rose(exposure_active) |-> frame_start;
  endproperty
  a_fs_rise: assert property (p_fs_rise) else $error("no frame start at exposure start");
  property p_fs_cause;
    frame_start |-> $rose(exposure_active);
  endproperty
  a_fs_cause: assert property (p_fs_cause) else $error("frame start inside an exposure");
  property p_fs_pulse;
    frame_start |=> !frame_start;
  endproperty
  a_fs_pulse: assert property (p_fs_pulse) else $error("frame start longer than one cycle");
  property p_busy;
    exposure_active |-> !trigger_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while exposing");
  property p_min;
    $fell(exposure_active) |-> exp_cnt_r >= MIN_CYC;
  endproperty
  a_min: assert property (p_min) else $error("exposure below minimum");
  property p_rst;
    $fell(srst) |-> !exposure_active && !trigger_ready && !irq && !frame_start;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_pready;
    apb_req.psel && apb_req.penable |-> apb_rsp.pready;
  endproperty
  a_pready: assert property (p_pready) else $error("access phase without ready");
  property p_slverr;
    apb_rsp.pslverr |-> apb_req.psel && apb_req.penable;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error outside access phase");
  c_frame: cover property (frame_start);
  c_irq: cover property ($rose(irq));
  c_err: cover property (apb_rsp.pslverr);
endmodule : exp_timer_chk

bind exposure_timer_trigger_delay exp_timer_chk #(.MIN_EXP_US(MIN_EXP_US)) u_chk (
  .sys_clk(sys_clk),
  .srst(srst),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .exposure_active(exposure_active),
  .trigger_ready(trigger_ready),
  .frame_start(frame_start),
  .irq(irq)
);

// ### trig_src.sv
/*
  External trigger source driving the two camera input lines.
  Assumes its tasks are called just after a rising sys_clk edge.
*/
`timescale 1ns/1ps
module trig_src (
  // clock
  input wire logic sys_clk,
  // input lines
  output logic [1:0] trig_line
);
  logic [1:0] idle_r = 2'h0;
  initial trig_line = 2'h0;
  // idle level matches the chosen activation so the first edge is the active one
  task automatic set_idle(input logic [1:0] lvl);
    idle_r = lvl;
    trig_line <= lvl;
  endtask : set_idle
  task automatic pulse(input int ln, input int hi);
    trig_line[ln] <= ~idle_r[ln];
    repeat (hi) @(posedge sys_clk);
    trig_line[ln] <= idle_r[ln];
  endtask : pulse
endmodule : trig_src

// ### exposure_timer_trigger_delay_tb.sv
/*
  Self-checking bench: standard and restricted variants on one APB master.
  Assumes the trigger source model drives the input lines.
*/
`timescale 1ns/1ps
module exposure_timer_trigger_delay_tb;
  import exp_timer_pkg::*;
  logic sys_clk, srst, sel, ea, tr, fs, irq, se;
  apb_req_t rq, ra, rb;
  apb_rsp_t rs, rs2, rsx;
  logic [1:0] tl;
  logic [31:0] rd, v, cm, cb;
  logic [15:0] lf = 16'he807;
  int lat, cnt;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] tv [4] = '{32'h0, 32'h1000, 32'h1, 32'hfff};
  logic [31:0] bv [3] = '{32'h0, 32'h989681, 32'h989680};
  // select routes the one master to either variant
  always_comb begin
    ra = rq;
    ra.psel = rq.psel & ~sel;
    rb = rq;
    rb.psel = rq.psel & sel;
  end
  assign rsx = sel ? rs2 : rs;
  trig_src src (.sys_clk(sys_clk), .trig_line(tl));
  exposure_timer_trigger_delay #(.RESTRICTED(1'b0), .MIN_EXP_US(MIN_DUR_DEF)) uut (
    .sys_clk(sys_clk), .srst(srst), .apb_req(ra), .apb_rsp(rs), .trig_line(tl),
    .exposure_active(ea), .trigger_ready(tr), .frame_start(fs), .irq(irq));
  exposure_timer_trigger_delay #(.RESTRICTED(1'b1), .MIN_EXP_US(24'h00007c)) uut2 (
    .sys_clk(sys_clk), .srst(srst), .apb_req(rb), .apb_rsp(rs2), .trig_line(tl),
    .exposure_active(), .trigger_ready(), .frame_start(), .irq());
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  function automatic logic [31:0] dur(input logic [31:0] m, input logic [31:0] b, input logic [31:0] mx,
                                      input logic [31:0] mn);
    logic [63:0] p;
    p = m * b;
    if (p > mx) p = mx;
    if (p < mn) p = mn;
    return p[31:0];
  endfunction : dur
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    rq.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsx.pready !== 1'b1) @(posedge sys_clk);
    rd = rsx.prdata;
    se = rsx.pslverr;
    rq <= '0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk
  // cycles until exposure starts, then cycles it lasts
  task automatic meas();
    lat = 0;
    cnt = 0;
    while (ea !== 1'b1) begin
      @(posedge sys_clk);
      lat++;
    end
    while (ea === 1'b1) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask : meas
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    srst = 1'b1;
    sel = 1'b0;
    rq = '0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rdchk(A_BASE, 32'h14, "base");
    rdchk(A_DUR, 32'h7d0, "dur");
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", se, 32'h1);
    cm = 32'h64;
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      v = (i < 4) ? tv[i] : {20'h0, lf[11:0]};
      apb(1'b1, A_MULT, v);
      if (v >= 32'h1 && v <= 32'hfff) cm = v;
      rdchk(A_MULT, cm, "mult");
      rdchk(A_DUR, dur(cm, 32'h14, MAX_DUR_STD, MIN_DUR_DEF), "dur");
    end
    apb(1'b1, A_MULT, 32'h1);
    cb = 32'h14;
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      v = (i < 3) ? bv[i] : {22'h0, lf[9:0]} + 32'h1;
      apb(1'b1, A_BASE, v);
      if (v != 32'h0 && v <= MAX_DUR_STD) cb = v;
      rdchk(A_DUR, dur(32'h1, cb, MAX_DUR_STD, MIN_DUR_DEF), "dur_base");
    end
    sel <= 1'b1;
    @(posedge sys_clk);
    rdchk(A_BASE, 32'h1f, "base_res");
    apb(1'b1, A_BASE, 32'h28);
    rdchk(A_BASE, 32'h1f, "base_res");
    apb(1'b1, A_BASE, 32'h3e);
    apb(1'b1, A_MULT, 32'h800);
    rdchk(A_DUR, 32'h1f000, "dur_res");
    apb(1'b1, A_MULT, 32'hfff);
    rdchk(A_DUR, 32'h1f000, "dur_res");
    apb(1'b1, A_MULT, 32'h1);
    rdchk(A_DUR, 32'h7c, "dur_min");
    sel <= 1'b0;
    @(posedge sys_clk);
    apb(1'b1, A_BASE, 32'h3e);
    apb(1'b1, A_DUR, 32'h82);
    rdchk(A_MULT, 32'h2, "mult_abs");
    apb(1'b1, A_DUR, 32'ha0);
    rdchk(A_DUR, 32'hba, "dur_abs");
    apb(1'b1, A_AUTO, 32'h4d2);
    apb(1'b1, A_CTRL, 32'h50);
    rdchk(A_CTRL, 32'h10, "ctrl");
    apb(1'b1, A_DELAY, 32'h32);
    apb(1'b1, A_CTRL, 32'h40);
    apb(1'b1, A_CMD, 32'h1);
    meas();
    chk("free_lat", lat < 50, 32'h1);
    chk("auto_len", (cnt + 5) / 10, 32'h4d2);
    apb(1'b1, A_CMD, 32'h2);
    while (ea === 1'b1) @(posedge sys_clk);
    apb(1'b1, A_IRQ_STAT, 32'h7);
    apb(1'b1, A_BASE, 32'h14);
    apb(1'b1, A_MULT, 32'h5);
    apb(1'b1, A_CTRL, 32'h5);
    apb(1'b1, A_CMD, 32'h1);
    apb(1'b1, A_CMD, 32'h4);
    meas();
    chk("sw_lat", lat < 50, 32'h1);
    chk("sw_len", (cnt + 5) / 10, 32'h64);
    chk("irq_masked", irq, 32'h0);
    rdchk(A_IRQ_STAT, 32'h6, "stat");
    apb(1'b1, A_IRQ_STAT, 32'h7);
    apb(1'b1, A_IRQ_MASK, 32'h7);
    apb(1'b1, A_CTRL, 32'h1);
    fork
      src.pulse(0, 20);
      meas();
      begin
        repeat (1020) @(posedge sys_clk);
        src.pulse(0, 20);
      end
    join
    chk("delay", lat / 10, 32'h32);
    chk("len", (cnt + 5) / 10, 32'h64);
    chk("irq", irq, 32'h1);
    rdchk(A_IRQ_STAT, 32'h7, "stat_over");
    apb(1'b1, A_IRQ_STAT, 32'h7);
    chk("irq_clr", irq, 32'h0);
    src.set_idle(2'h2);
    apb(1'b1, A_DELAY, 32'h0);
    apb(1'b1, A_CTRL, 32'h1b);
    fork
      src.pulse(1, 300);
      meas();
    join
    chk("width", (cnt + 5) / 10, 32'h1e);
    // pacing on: a trigger after the exposure but inside the frame period is refused
    apb(1'b1, A_PERIOD, 32'hc8);
    apb(1'b1, A_CTRL, 32'h21);
    apb(1'b1, A_IRQ_STAT, 32'h7);
    fork
      src.pulse(0, 20);
      begin
        repeat (1300) @(posedge sys_clk);
        src.pulse(0, 20);
      end
    join
    chk("paced", tr, 32'h0);
    rdchk(A_IRQ_STAT, 32'h7, "stat_pace");
    repeat (800) @(posedge sys_clk);
    chk("ready", tr, 32'h1);
    test_done();
  end
endmodule : exposure_timer_trigger_delay_tb
